// [logic/timer_pkg.sv]
// Shared constants, types and helpers for the timer/event counter block
package timer_pkg;

	// ************************************************************
	// Register map: address = {page, timer index, field}
	// ************************************************************
	localparam logic [3:0] ADDR_PAGE   = 4'h0;
	localparam logic [1:0] FIELD_CTRL  = 2'h0;
	localparam logic [1:0] FIELD_LOW   = 2'h1;
	localparam logic [1:0] FIELD_HIGH  = 2'h2;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int         MODE_HI     = 7;
	localparam int         MODE_LO     = 6;
	localparam int         RUN_BIT     = 4;
	localparam int         EDGE_BIT    = 3;
	localparam logic [7:0] CTRL_MASK   = 8'hd8;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [1:0] MODE_TIMER  = 2'h2;
	localparam logic [1:0] MODE_EVENT  = 2'h1;
	localparam logic [1:0] MODE_PULSE  = 2'h3;

	// ************************************************************
	// Counter and clock figures
	// ************************************************************
	localparam logic [15:0] COUNT_FULL   = 16'hffff;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          SYS_CLK_HZ   = 1000000000 / CLK_PERIOD_NS;
	localparam int          SLOW_CLK_HZ  = 32768;
	localparam logic [1:0]  FAST_DIV_LAST = 2'h3;
	localparam int          PHASE_W      = 28;
	localparam logic [PHASE_W:0] PHASE_MOD = (PHASE_W+1)'(SYS_CLK_HZ);
	localparam logic [PHASE_W:0] PHASE_STEP = (PHASE_W+1)'(SLOW_CLK_HZ);

	typedef enum logic [1:0] {pw_wait, pw_count} pw_state_type;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic reg_hit(input logic [7:0] addr,
		input logic [1:0] idx, input logic [1:0] field);
		reg_hit = (addr == {ADDR_PAGE, idx, field});
	endfunction

	// Edge that opens a pulse: falling when select is low
	function automatic logic lead_edge(input logic sel,
		input logic rise, input logic fall);
		lead_edge = sel ? rise : fall;
	endfunction

	// Edge that counts events and closes a pulse
	function automatic logic trail_edge(input logic sel,
		input logic rise, input logic fall);
		trail_edge = sel ? fall : rise;
	endfunction

endpackage

// [logic/tick_divider.sv]
// Timer clock enables: system clock / 4 and an exact-average 32768 Hz
`timescale 1ns/10ps
module tick_divider (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst,
	// Enables
	output logic      o_fast_tick,
	output logic      o_slow_tick
);
	typedef struct packed {
		logic [1:0]                     div_cnt;
		logic [timer_pkg::PHASE_W-1:0]  phase;
		logic                           fast_tick;
		logic                           slow_tick;
	} div_state_type;

	div_state_type s_q;
	div_state_type s_d;

	// Phase accumulator: no integer ratio exists, so average rate is exact
	always_comb
	begin
		logic [timer_pkg::PHASE_W:0] sum;
		sum = {1'b0, s_q.phase} + timer_pkg::PHASE_STEP;
		s_d = s_q;
		s_d.div_cnt = s_q.div_cnt + 2'h1;
		s_d.fast_tick = (s_q.div_cnt == timer_pkg::FAST_DIV_LAST);
		s_d.slow_tick = 1'b0;
		if (sum >= timer_pkg::PHASE_MOD)
		begin
			sum = sum - timer_pkg::PHASE_MOD;
			s_d.slow_tick = 1'b1;
		end
		s_d.phase = sum[timer_pkg::PHASE_W-1:0];
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_fast_tick = s_q.fast_tick;
	assign o_slow_tick = s_q.slow_tick;
endmodule

// [logic/pin_edge_detect.sv]
// Two-flop synchroniser and edge detector for a timer pin
`timescale 1ns/10ps
module pin_edge_detect (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst,
	// Pin and edges
	input  wire logic i_pin,
	output logic      o_rise,
	output logic      o_fall
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
		logic rise;
		logic fall;
	} edge_state_type;

	edge_state_type s_q;
	edge_state_type s_d;

	// Only the second flop is looked at, so each edge shows once
	always_comb
	begin
		s_d = s_q;
		s_d.meta = i_pin;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		s_d.rise = s_q.sync & ~s_q.prev;
		s_d.fall = ~s_q.sync & s_q.prev;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_rise = s_q.rise;
	assign o_fall = s_q.fall;
endmodule

// [logic/timer_event_counter_modes.sv]
// Three 16-bit timer counters with mode, run and edge control; timers 0 and 1 also count pin events
// How it works
// (R1) Control bits 7:6 select operating mode
// (R2) Control bit 4 runs or stops counter
// (R3) Control bit 3 selects active pin edge
// (R4) Timer mode counts internal timer clock
// (R5) Overflow raises request, reloads preload, continues
// (R6) Interrupt passes only when enable set
// (R7) Event mode clocks from pin, no prescaler
// (R8) Event mode, select low: count rising
// (R9) Event mode, select high: count falling
// (R10) Event counting continues in power down, wakes
// (R11) Mode value 11 selects pulse width
// (R12) Pulse mode: run arms, edge starts
// (R13) Select low: fall starts, rise stops, clear
// (R14) Select high: rise starts, fall stops, clear
// (R15) Hardware clears run only in pulse mode
// (R16) After pulse, hold count, ignore pin
// (R17) Pulse start/stop use transitions, not levels
// (R18) Sixteen-bit up count, overflow after ffff
// (R19) Preload loads counter when stopped, else overflow
// (R20) Low write buffered; high read latches low
// (R21) Clocks: sys/4, 32768 Hz, timer 2 internal
// (R22) Mode 10 timer, mode 01 event
// (R23) Pin synchronised before edge detection
// (R24) Stopped counter holds and later resumes
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
module timer_event_counter_modes (
	// Clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	// Timer pins and system state
	input  wire logic       i_tmr0_pin,
	input  wire logic       i_tmr1_pin,
	input  wire logic       i_power_down,
	input  wire logic [2:0] i_irq_enable,
	// Events
	output logic      [2:0] o_overflow,
	output logic      [2:0] o_irq,
	output logic            o_wakeup
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [2:0][7:0]                  ctl;
		logic [2:0][15:0]                 cnt;
		logic [2:0][15:0]                 pre;
		logic [2:0][7:0]                  low_buf;
		logic [2:0][7:0]                  rd_latch;
		timer_pkg::pw_state_type [2:0]    pw;
		logic [7:0]                       rdata;
		logic [2:0]                       ovf;
		logic [2:0]                       irq;
		logic                             wake;
	} state_type;

	state_type  s_q;
	state_type  s_d;
	logic       fast_tick;
	logic       slow_tick;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic [2:0] int_tick;
	logic [2:0] wr_hit;

	// ************************************************************
	// Timer clocks and pin edges
	// ************************************************************
	tick_divider u_div (
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.o_fast_tick (fast_tick),
		.o_slow_tick (slow_tick)
	);

	pin_edge_detect u_pin0 ( // R23
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_pin  (i_tmr0_pin),
		.o_rise (pin_rise[0]),
		.o_fall (pin_fall[0])
	);

	pin_edge_detect u_pin1 ( // R23
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_pin  (i_tmr1_pin),
		.o_rise (pin_rise[1]),
		.o_fall (pin_fall[1])
	);

	// Timer 2 has no pin, so event and pulse modes never move it
	assign pin_rise[2] = 1'b0; // R21
	assign pin_fall[2] = 1'b0; // R21
	assign int_tick = {1'b1, slow_tick, fast_tick}; // R21

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb
	begin
		logic [1:0]  mode;
		logic        run;
		logic        sel;
		logic        lead;
		logic        trail;
		logic        tick;
		logic [15:0] load;
		mode = '0;
		run = 1'b0;
		sel = 1'b0;
		lead = 1'b0;
		trail = 1'b0;
		tick = 1'b0;
		load = '0;
		wr_hit = '0;
		s_d = s_q;
		s_d.ovf = '0;
		s_d.rdata = '0;
		for (int i = 0; i < 3; i++)
		begin
			mode = s_q.ctl[i][timer_pkg::MODE_HI:timer_pkg::MODE_LO]; // R1
			run = s_q.ctl[i][timer_pkg::RUN_BIT]; // R2
			sel = s_q.ctl[i][timer_pkg::EDGE_BIT]; // R3
			lead = timer_pkg::lead_edge(sel, pin_rise[i], pin_fall[i]); // R17
			trail = timer_pkg::trail_edge(sel, pin_rise[i], pin_fall[i]);
			// Pulse capture: armed by run, opened and closed by edges
			if (mode != timer_pkg::MODE_PULSE || !run) // R16
				s_d.pw[i] = timer_pkg::pw_wait;
			else
			begin
				unique case (s_q.pw[i])
					timer_pkg::pw_wait:
						if (lead) // R12 R13 R14
							s_d.pw[i] = timer_pkg::pw_count;
					timer_pkg::pw_count:
						if (trail)
						begin
							s_d.pw[i] = timer_pkg::pw_wait;
							s_d.ctl[i][timer_pkg::RUN_BIT] = 1'b0; // R13 R14 R15
						end
				endcase
			end
			// Count source per mode
			tick = 1'b0;
			if (run) // R2 R24
			begin
				unique case (mode)
					timer_pkg::MODE_TIMER: // R22
						tick = int_tick[i] & ~i_power_down; // R4
					timer_pkg::MODE_EVENT: // R22
						tick = trail; // R7 R8 R9 R10
					timer_pkg::MODE_PULSE: // R11
						tick = (s_q.pw[i] == timer_pkg::pw_count) &
							int_tick[i] & ~i_power_down; // R12
					default:
						tick = 1'b0;
				endcase
			end
			if (tick)
			begin
				if (s_q.cnt[i] == timer_pkg::COUNT_FULL) // R18
				begin
					s_d.cnt[i] = s_q.pre[i]; // R5
					s_d.ovf[i] = 1'b1; // R5
				end
				else
					s_d.cnt[i] = s_q.cnt[i] + 16'h0001; // R18
			end
			// Software writes; a control write beats the hardware clear
			wr_hit[i] = i_wr &&
				(timer_pkg::reg_hit(i_addr, 2'(i), timer_pkg::FIELD_CTRL) ||
				timer_pkg::reg_hit(i_addr, 2'(i), timer_pkg::FIELD_HIGH));
			if (i_wr && timer_pkg::reg_hit(i_addr, 2'(i),
				timer_pkg::FIELD_CTRL))
				s_d.ctl[i] = i_wdata & timer_pkg::CTRL_MASK; // R1 R2 R3
			if (i_wr && timer_pkg::reg_hit(i_addr, 2'(i),
				timer_pkg::FIELD_LOW))
				s_d.low_buf[i] = i_wdata; // R20
			if (i_wr && timer_pkg::reg_hit(i_addr, 2'(i),
				timer_pkg::FIELD_HIGH))
			begin
				load = {i_wdata, s_q.low_buf[i]}; // R20
				s_d.pre[i] = load;
				if (!run)
					s_d.cnt[i] = load; // R19
			end
			// Reads; the low byte comes from the latch, never live
			if (i_rd && timer_pkg::reg_hit(i_addr, 2'(i),
				timer_pkg::FIELD_CTRL))
				s_d.rdata = s_q.ctl[i];
			if (i_rd && timer_pkg::reg_hit(i_addr, 2'(i),
				timer_pkg::FIELD_HIGH))
			begin
				s_d.rdata = s_q.cnt[i][15:8];
				s_d.rd_latch[i] = s_q.cnt[i][7:0]; // R20
			end
			if (i_rd && timer_pkg::reg_hit(i_addr, 2'(i),
				timer_pkg::FIELD_LOW))
				s_d.rdata = s_q.rd_latch[i]; // R20
			s_d.irq[i] = s_d.ovf[i] & i_irq_enable[i]; // R6
		end
		// Wake-up does not depend on the interrupt enables
		s_d.wake = (|s_d.ovf) & i_power_down; // R10
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s_q <= '0;
			s_q.ctl <= {3{timer_pkg::CTRL_RESET}};
			s_q.cnt <= {3{timer_pkg::COUNT_RESET}};
			s_q.pre <= {3{timer_pkg::COUNT_RESET}};
		end
		else
			s_q <= s_d;
	end

	assign o_rdata = s_q.rdata;
	assign o_overflow = s_q.ovf;
	assign o_irq = s_q.irq;
	assign o_wakeup = s_q.wake;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_run_hold;
		@(posedge i_mclk) disable iff (i_rst)
		!s_q.ctl[0][timer_pkg::RUN_BIT] && !wr_hit[0] |=>
			$stable(s_q.cnt[0]);
	endproperty
	a_run_hold: assert property (p_run_hold) // R2 R24
		else $error("stopped counter changed");

	property p_timer_step;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[0][7:4] == 4'h9 && fast_tick && !i_power_down &&
			s_q.cnt[0] != timer_pkg::COUNT_FULL && !wr_hit[0] |=>
			s_q.cnt[0] == $past(s_q.cnt[0]) + 16'h0001;
	endproperty
	a_timer_step: assert property (p_timer_step) // R4
		else $error("timer mode did not step");

	property p_reload;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[1][7:4] == 4'h9 && slow_tick && !i_power_down &&
			s_q.cnt[1] == timer_pkg::COUNT_FULL && !wr_hit[1] |=>
			o_overflow[1] && s_q.cnt[1] == $past(s_q.pre[1]);
	endproperty
	a_reload: assert property (p_reload) // R5
		else $error("overflow did not reload");

	property p_irq_gate;
		@(posedge i_mclk) disable iff (i_rst)
		o_irq[0] == (o_overflow[0] && $past(i_irq_enable[0]));
	endproperty
	a_irq_gate: assert property (p_irq_gate) // R6
		else $error("interrupt not gated by enable");

	property p_event_edge;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[1][7:4] == 4'h5 && s_q.cnt[1] != timer_pkg::COUNT_FULL &&
			!wr_hit[1] && (s_q.ctl[1][3] ? pin_fall[1] : pin_rise[1]) |=>
			s_q.cnt[1] == $past(s_q.cnt[1]) + 16'h0001;
	endproperty
	a_event_edge: assert property (p_event_edge) // R8 R9
		else $error("event edge not counted");

	property p_pulse_stop;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.pw[0] == timer_pkg::pw_count && s_q.ctl[0][7:4] == 4'hd &&
			(s_q.ctl[0][3] ? pin_fall[0] : pin_rise[0]) && !wr_hit[0] |=>
			!s_q.ctl[0][timer_pkg::RUN_BIT] ##1 $stable(s_q.cnt[0]);
	endproperty
	a_pulse_stop: assert property (p_pulse_stop) // R13 R14 R16
		else $error("pulse end did not stop counter");

	property p_no_hw_clear;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[0][timer_pkg::RUN_BIT] && s_q.ctl[0][7:6] != 2'h3 &&
			!wr_hit[0] |=> s_q.ctl[0][timer_pkg::RUN_BIT];
	endproperty
	a_no_hw_clear: assert property (p_no_hw_clear) // R15
		else $error("run bit cleared outside pulse mode");

	property p_preload_stopped;
		@(posedge i_mclk) disable iff (i_rst)
		i_wr && i_addr == 8'h02 && !s_q.ctl[0][timer_pkg::RUN_BIT] |=>
			s_q.cnt[0] == {$past(i_wdata), $past(s_q.low_buf[0])};
	endproperty
	a_preload_stopped: assert property (p_preload_stopped) // R19 R20
		else $error("stopped preload not loaded");

	property p_high_read;
		@(posedge i_mclk) disable iff (i_rst)
		i_rd && i_addr == 8'h06 |=>
			o_rdata == $past(s_q.cnt[1][15:8]) &&
			s_q.rd_latch[1] == $past(s_q.cnt[1][7:0]);
	endproperty
	a_high_read: assert property (p_high_read) // R20
		else $error("high read did not latch low byte");

	property p_wake;
		@(posedge i_mclk) disable iff (i_rst)
		o_wakeup == ((|o_overflow) && $past(i_power_down));
	endproperty
	a_wake: assert property (p_wake) // R10
		else $error("wake-up not tied to overflow in power down");

	property p_timer2_step;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[2][7:4] == 4'h9 && !i_power_down &&
			s_q.cnt[2] != timer_pkg::COUNT_FULL && !wr_hit[2] |=>
			s_q.cnt[2] == $past(s_q.cnt[2]) + 16'h0001;
	endproperty
	a_timer2_step: assert property (p_timer2_step) // R4 R21
		else $error("timer 2 did not step every cycle");

	property p_pulse_armed;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[0][7:4] == 4'hd && s_q.pw[0] == timer_pkg::pw_wait &&
			!wr_hit[0] |=> $stable(s_q.cnt[0]);
	endproperty
	a_pulse_armed: assert property (p_pulse_armed) // R12 R17
		else $error("armed pulse counter moved before edge");

	property p_pulse_idle;
		@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[0][7:6] == timer_pkg::MODE_PULSE &&
			!s_q.ctl[0][timer_pkg::RUN_BIT] |=> s_q.pw[0] == timer_pkg::pw_wait;
	endproperty
	a_pulse_idle: assert property (p_pulse_idle) // R16
		else $error("stopped pulse capture left waiting state");

	c_overflow: cover property (@(posedge i_mclk) disable iff (i_rst)
		o_overflow[0]);
	c_pulse_done: cover property (@(posedge i_mclk) disable iff (i_rst)
		s_q.pw[0] == timer_pkg::pw_count ##1 s_q.pw[0] == timer_pkg::pw_wait);
	c_wake: cover property (@(posedge i_mclk) disable iff (i_rst)
		o_wakeup);
	c_event_count: cover property (@(posedge i_mclk) disable iff (i_rst)
		s_q.ctl[1][7:4] == 4'h5 && pin_rise[1]);
	c_irq1: cover property (@(posedge i_mclk) disable iff (i_rst)
		o_overflow[1] && o_irq[1]);
endmodule

// [test/pulse_source.sv]
// Pulse source model that drives one timer pin
`timescale 1ns/10ps
module pulse_source (
	// Clock and control
	input  wire logic        i_mclk,
	input  wire logic        i_idle,
	input  wire logic        i_start,
	input  wire logic [15:0] i_width,
	// Pin
	output logic             o_pin,
	output logic             o_busy
);
	logic [15:0] left_q = 16'h0000;

	// Each level is held far longer than three cycles, so the
	// synchroniser sees every transition once
	always @(posedge i_mclk)
	begin
		if (i_start)
			left_q <= i_width;
		else if (left_q != 16'h0000)
			left_q <= left_q - 16'h0001;
	end
	assign o_busy = (left_q != 16'h0000);
	assign o_pin  = i_idle ^ o_busy;
endmodule

// [test/tb_top.sv]
// Self-checking bench for the timer/event counter block
`timescale 1ns/10ps
module tb_top;
	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} row_type;
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  i_addr = 8'h00;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [7:0]  o_rdata;
	logic        i_power_down = 1'b0;
	logic [2:0]  i_irq_enable = 3'h0;
	logic [2:0]  o_overflow;
	logic [2:0]  o_irq;
	logic        o_wakeup;
	logic [1:0]  pin;
	logic [1:0]  busy;
	logic [1:0]  idle = 2'h0;
	logic [1:0]  start = 2'h0;
	logic [15:0] v;
	logic [15:0] w;
	logic [7:0]  b;
	int          errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	// Unmapped places sit among the rows; control bits 5, 2:0 read 0
	row_type     rows [8] = '{'{8'h00, 8'hff, 8'hd8}, '{8'h04, 8'h5c, 8'h58},
		'{8'h08, 8'hd0, 8'hd0}, '{8'h03, 8'haa, 8'h00},
		'{8'hff, 8'h55, 8'h00}, '{8'h00, 8'h00, 8'h00},
		'{8'h04, 8'h00, 8'h00}, '{8'h08, 8'h00, 8'h00}};

	timer_event_counter_modes u_timer_event_counter_modes (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_tmr0_pin(pin[0]), .i_tmr1_pin(pin[1]),
		.i_power_down(i_power_down), .i_irq_enable(i_irq_enable),
		.o_overflow(o_overflow), .o_irq(o_irq), .o_wakeup(o_wakeup));
	pulse_source u_pulse_source0 (.i_mclk(i_mclk), .i_idle(idle[0]),
		.i_start(start[0]), .i_width(16'h0028), .o_pin(pin[0]),
		.o_busy(busy[0]));
	pulse_source u_pulse_source1 (.i_mclk(i_mclk), .i_idle(idle[1]),
		.i_start(start[1]), .i_width(16'h0028), .o_pin(pin[1]),
		.o_busy(busy[1]));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic end_sim;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// High byte first, so the low byte comes from the latch
	task automatic rd16(input int i, output logic [15:0] d);
		rd({4'h0, i[1:0], 2'h2}, d[15:8]);
		rd({4'h0, i[1:0], 2'h1}, d[7:0]);
	endtask
	task automatic ld(input int i, input logic [15:0] d);
		wr({4'h0, i[1:0], 2'h1}, d[7:0]);
		wr({4'h0, i[1:0], 2'h2}, d[15:8]);
	endtask
	task automatic pulse(input int i);
		@(posedge i_mclk);
		start[i] <= 1'b1;
		@(posedge i_mclk);
		start[i] <= 1'b0;
	endtask
	// Waits for an overflow, then times the next one unless hi is 0
	task automatic gap(input int i, input int lo, input int hi);
		int n;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			#1 n++;
		end
		while (o_overflow[i] !== 1'b1 && n < 20000);
		chk({15'h0, o_overflow[i]}, 16'h0001);
		chk({15'h0, o_irq[i]}, {15'h0, i_irq_enable[i]});
		chk({15'h0, o_wakeup}, {15'h0, i_power_down});
		if (hi == 0)
			return;
		n = 0;
		do
		begin
			@(posedge i_mclk);
			#1 n++;
		end
		while (o_overflow[i] !== 1'b1 && n < 20000);
		chk({15'h0, n >= lo && n <= hi}, 16'h0001);
	endtask

	// ************************************************************
	// Clock, timeout and sequence
	// ************************************************************
	initial
	begin
		forever #2 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			errors++;
			end_sim;
		end
	end
	initial
	begin
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			rd({4'h0, i[1:0], 2'h0}, b);
			chk({8'h0, b}, 16'h0000);
			rd16(i, v);
			chk(v, 16'h0000);
		end
		foreach (rows[r])
		begin
			wr(rows[r].addr, rows[r].wdata);
			rd(rows[r].addr, b);
			chk({8'h0, b}, {8'h0, rows[r].exp});
		end
		ld(0, 16'h9b1f);
		rd16(0, v);
		chk(v, 16'h9b1f);
		wr(8'h01, 8'h55);
		rd16(0, v);
		chk(v, 16'h9b1f);
		rd(8'h01, b);
		chk({8'h0, b}, 16'h001f);
		// Timer 2 every cycle, with and without the enable
		i_irq_enable <= 3'h4;
		ld(2, 16'hfffe);
		wr(8'h08, 8'h80);
		wr(8'h08, 8'h90);
		gap(2, 2, 2);
		i_irq_enable <= 3'h0;
		gap(2, 2, 2);
		wr(8'h08, 8'h80);
		rd16(2, v);
		repeat (8) @(posedge i_mclk);
		rd16(2, w);
		chk(w, v);
		wr(8'h08, 8'h90);
		gap(2, 2, 2);
		wr(8'h08, 8'h00);
		// Timer 0 at a quarter rate, preload written while running; then timer 1 at 32768 Hz
		ld(0, 16'hffff);
		wr(8'h00, 8'h80);
		wr(8'h00, 8'h90);
		gap(0, 4, 4);
		ld(0, 16'hfff0);
		gap(0, 64, 64);
		wr(8'h00, 8'h00);
		ld(1, 16'hffff);
		wr(8'h04, 8'h80);
		wr(8'h04, 8'h90);
		gap(1, 7628, 7631);
		wr(8'h04, 8'h00);
		// Event counting on timer 1, both edges
		for (int s = 0; s < 2; s++)
		begin
			wr(8'h04, {4'h4, s[0], 3'h0});
			ld(1, 16'h0000);
			wr(8'h04, {4'h5, s[0], 3'h0});
			pulse(1);
			repeat (20) @(posedge i_mclk);
			rd16(1, v);
			chk(v, {15'h0, ~s[0]});
			repeat (30) @(posedge i_mclk);
			rd16(1, v);
			chk(v, 16'h0001);
			rd(8'h04, b);
			chk({8'h0, b}, {8'h0, 4'h5, s[0], 3'h0});
		end
		// Overflow while powered down wakes the processor
		wr(8'h04, 8'h40);
		ld(1, 16'hffff);
		wr(8'h04, 8'h50);
		i_irq_enable <= 3'h2;
		i_power_down <= 1'b1;
		pulse(1);
		gap(1, 0, 0);
		i_power_down <= 1'b0;
		wr(8'h04, 8'h00);
		// Pulse width on timer 0; idle level set opposite the start edge
		for (int s = 0; s < 2; s++)
		begin
			idle[0] <= ~s[0];
			repeat (8) @(posedge i_mclk);
			ld(0, 16'h0000);
			wr(8'h00, {4'hc, s[0], 3'h0});
			wr(8'h00, {4'hd, s[0], 3'h0});
			repeat (8) @(posedge i_mclk);
			rd16(0, v);
			chk(v, 16'h0000);
			pulse(0);
			repeat (60) @(posedge i_mclk);
			chk({15'h0, busy[0]}, 16'h0000);
			rd(8'h00, b);
			chk({8'h0, b}, {8'h0, 4'hc, s[0], 3'h0});
			rd16(0, v);
			chk({15'h0, v >= 16'h0009 && v <= 16'h000b}, 16'h0001);
			pulse(0);
			repeat (60) @(posedge i_mclk);
			rd16(0, w);
			chk(w, v);
			wr(8'h00, 8'h00);
		end
		// Reset in mid-run clears control and outputs
		wr(8'h08, 8'h90);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		#1 chk({13'h0, o_overflow}, 16'h0000);
		i_rst <= 1'b0;
		rd(8'h08, b);
		chk({8'h0, b}, 16'h0000);
		end_sim;
	end
endmodule
